// ### ptpc_pkg.sv
// Shared constants for the periodic timer pulse and capture block
package ptpc_pkg;
  // ----------------------------------------
  // Counter geometry
  // ----------------------------------------
  localparam int CNT_W = 10;
  localparam logic [9:0] CNT_MAX = 10'h3FF;
  localparam logic [9:0] CNT_RST = 10'h000;
  localparam logic [9:0] COMPARE_A_VALUE_RST = 10'h000;
  // ----------------------------------------
  // Mode select and pin function codes
  // ----------------------------------------
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_SINGLE = 2'h2;
  localparam logic [1:0] PF_SINGLE = 2'h3;
  localparam logic [1:0] PF_RISE = 2'h0;
  localparam logic [1:0] PF_FALL = 2'h1;
  localparam logic [1:0] PF_BOTH = 2'h2;
  localparam logic [1:0] PF_NONE = 2'h3;
endpackage

// ### ptpc_edge.sv
// Pin synchroniser with rise and fall pulse outputs
`timescale 1ns/1ns
module ptpc_edge
  import ptpc_pkg::*;
(
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  logic meta_nxt;
  logic sync_nxt;
  logic last_nxt;
  logic [2:0] fill_r;
  logic [2:0] fill_nxt;

  always_comb
  begin
    meta_nxt = pin_in;
    sync_nxt = meta_r;
    last_nxt = sync_r;
    fill_nxt = {fill_r[1:0], 1'b1};
  end

  // ----------------------------------------
  // Two stages, then edge history
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      fill_r <= 3'h0;
    end
    else
    begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
      fill_r <= fill_nxt;
    end
  end

  // Edges only look past the first stage
  // Held off until history is real; a pin idling high would fake an edge
  assign rise_out = sync_r & ~last_r & fill_r[2];
  assign fall_out = ~sync_r & last_r & fill_r[2];
endmodule

// ### ptpc_timer.sv
// Periodic timer: single pulse output and input capture modes
// How it works
// - Run bit rising starts counter and drives pulse leading edge.
// - External clock pin rising edge sets run bit in single pulse mode.
// - Run bit clear ends pulse; compare A match clears run bit.
// - Compare A match stops the counter in single pulse mode.
// - Compare A match raises compare A flag in single pulse mode.
// - Counter returns to zero when run bit rises or on period match.
// - Period register and clear select ignored in single pulse mode.
// - Source select picks capture pin or external clock pin.
// - Pin function selects rising, falling or both capture edges.
// - Pin function 11 disables capture; counter keeps running.
// - Capture counter starts on run rise, free runs until run falls.
// - Active edge copies counter into compare A and raises flag.
// - Period match zeroes counter and raises compare P flag.
// - Zero period gives the full counter range.
// - Clear select, initial state and polarity unused in capture.
// - Counter is 10 bits and wraps after 3FF.
// - Initial state bit sets pin level when run bit rises.
`timescale 1ns/1ns
module ptpc_timer
  import ptpc_pkg::*;
(
  input  wire logic              clock_in,
  input  wire logic              rst_b_in,
  input  wire logic              mode_select_hi_in,
  input  wire logic              mode_select_lo_in,
  input  wire logic              pin_function_hi_in,
  input  wire logic              pin_function_lo_in,
  input  wire logic              counter_clear_select_in,
  input  wire logic              output_initial_state_in,
  input  wire logic              output_polarity_in,
  input  wire logic              capture_source_select_in,
  input  wire logic              run_set_in,
  input  wire logic              run_clear_in,
  input  wire logic              compare_a_wr_in,
  input  wire logic [CNT_W-1:0]  compare_a_wdata_in,
  input  wire logic [CNT_W-1:0]  compare_p_period_in,
  input  wire logic              compare_a_flag_clr_in,
  input  wire logic              compare_p_flag_clr_in,
  input  wire logic              timer_ext_clock_pin_in,
  input  wire logic              capture_input_pin_in,
  output logic                   timer_run_bit_out,
  output logic [CNT_W-1:0]       counter_out,
  output logic [CNT_W-1:0]       compare_a_value_out,
  output logic                   timer_out_pin_out,
  output logic                   compare_a_irq_flag_out,
  output logic                   compare_p_irq_flag_out
);
  logic             rst_m_r;
  logic             rst_s_r;
  logic             ck_rise;
  logic             ck_fall;
  logic             cp_rise;
  logic             cp_fall;
  logic             run_r;
  logic             run_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] compare_a_value_r;
  logic [CNT_W-1:0] compare_a_value_nxt;
  logic             lvl_r;
  logic             lvl_nxt;
  logic             fa_r;
  logic             fa_nxt;
  logic             fp_r;
  logic             fp_nxt;
  logic             sp_mode;
  logic             cap_mode;
  logic             a_match;
  logic             p_match;
  logic             src_rise;
  logic             src_fall;
  logic             cap_ev;
  logic             run_rise;
  logic [1:0]       pf;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clock_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rst_m_r <= 1'b0;
      rst_s_r <= 1'b0;
    end
    else
    begin
      rst_m_r <= 1'b1;
      rst_s_r <= rst_m_r;
    end
  end

  ptpc_edge u_ck_edge (
    .clock_in (clock_in),
    .rst_b_in (rst_s_r),
    .pin_in   (timer_ext_clock_pin_in),
    .rise_out (ck_rise),
    .fall_out (ck_fall)
  );

  ptpc_edge u_cp_edge (
    .clock_in (clock_in),
    .rst_b_in (rst_s_r),
    .pin_in   (capture_input_pin_in),
    .rise_out (cp_rise),
    .fall_out (cp_fall)
  );

  // ----------------------------------------
  // Mode decode and events
  // ----------------------------------------
  assign pf = {pin_function_hi_in, pin_function_lo_in};
  assign sp_mode = ({mode_select_hi_in, mode_select_lo_in} == MODE_SINGLE) && (pf == PF_SINGLE);
  assign cap_mode = ({mode_select_hi_in, mode_select_lo_in} == MODE_CAPTURE);
  // compare A match only while counting
  assign a_match = sp_mode && run_r && (cnt_r == compare_a_value_r);
  // zero period never matches, counter wraps
  assign p_match = cap_mode && run_r && (compare_p_period_in != CNT_RST) && (cnt_r == compare_p_period_in);
  assign src_rise = capture_source_select_in ? ck_rise : cp_rise;
  assign src_fall = capture_source_select_in ? ck_fall : cp_fall;

  always_comb
  begin
    unique case (pf)
      PF_RISE: cap_ev = src_rise;
      PF_FALL: cap_ev = src_fall;
      PF_BOTH: cap_ev = src_rise | src_fall;
      PF_NONE: cap_ev = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    run_nxt = run_r;
    if (run_clear_in || a_match)
      run_nxt = 1'b0;
    // pin edge sets run bit; set wins over clear
    if (run_set_in || (sp_mode && ck_rise))
      run_nxt = 1'b1;
    run_rise = run_nxt && !run_r;

    cnt_nxt = cnt_r;
    // run rise or period match clears the counter
    if (run_rise)
      cnt_nxt = CNT_RST;
    else if (p_match)
      cnt_nxt = CNT_RST;
    // match stops counter; period unused in single pulse
    else if (run_r && !a_match && (sp_mode || cap_mode))
      cnt_nxt = cnt_r + 10'h001;

    compare_a_value_nxt = compare_a_wr_in ? compare_a_wdata_in : compare_a_value_r;
    if (cap_mode && cap_ev)
      compare_a_value_nxt = cnt_r;

    lvl_nxt = lvl_r;
    // initial level on run rise; leading edge
    if (sp_mode && run_rise)
      lvl_nxt = output_initial_state_in;
    else if (sp_mode && !run_nxt && run_r)
      lvl_nxt = ~output_initial_state_in;
    else if (!sp_mode)
      lvl_nxt = 1'b0;

    // Set wins over clear so no event is lost
    fa_nxt = fa_r & ~compare_a_flag_clr_in;
    if (a_match || (cap_mode && cap_ev))
      fa_nxt = 1'b1;
    fp_nxt = fp_r & ~compare_p_flag_clr_in;
    if (p_match)
      fp_nxt = 1'b1;
  end

  always_ff @(posedge clock_in or negedge rst_s_r)
  begin
    if (!rst_s_r)
    begin
      run_r  <= 1'b0;
      cnt_r  <= CNT_RST;
      compare_a_value_r <= COMPARE_A_VALUE_RST;
      lvl_r  <= 1'b0;
      fa_r   <= 1'b0;
      fp_r   <= 1'b0;
    end
    else
    begin
      run_r  <= run_nxt;
      cnt_r  <= cnt_nxt;
      compare_a_value_r <= compare_a_value_nxt;
      lvl_r  <= lvl_nxt;
      fa_r   <= fa_nxt;
      fp_r   <= fp_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign timer_run_bit_out      = run_r;
  assign counter_out            = cnt_r;
  assign compare_a_value_out    = compare_a_value_r;
  // polarity only applies in single pulse; clear select unread
  assign timer_out_pin_out      = sp_mode ? (lvl_r ^ output_polarity_in) : 1'b0;
  assign compare_a_irq_flag_out = fa_r;
  assign compare_p_irq_flag_out = fp_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence run_starts;
    !run_r ##1 run_r;
  endsequence

  // Level inputs steady across the start, so the leading level is known
  sequence pulse_armed;
    sp_mode && $past(sp_mode) && $stable(output_initial_state_in) && $stable(output_polarity_in);
  endsequence

  property cnt_zero_on_start;
    @(posedge clock_in) disable iff (!rst_s_r) run_starts |-> cnt_r == CNT_RST;
  endproperty

  start_clears_cnt_a : assert property (cnt_zero_on_start) else $error("counter not zero at start");

  a_match_stop_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    a_match && !run_set_in && !ck_rise |=> !run_r && fa_r && $stable(cnt_r))
    else $error("compare A did not stop");

  ext_pin_run_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    sp_mode && ck_rise |=> run_r) else $error("pin edge did not set run");

  p_match_wrap_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    p_match && !run_set_in |=> cnt_r == CNT_RST && fp_r) else $error("period match did not wrap");

  capture_copy_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    cap_mode && cap_ev |=> compare_a_value_r == $past(cnt_r) && fa_r) else $error("capture value wrong");

  free_run_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    cap_mode && run_r && !p_match && !run_set_in && $stable(mode_select_lo_in)
    |=> cnt_r == $past(cnt_r) + 10'h001) else $error("counter did not advance");

  no_cap_none_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    cap_mode && pf == PF_NONE && !compare_a_wr_in |=> $stable(compare_a_value_r)) else $error("capture while disabled");

  pulse_level_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    run_starts ##0 pulse_armed |-> timer_out_pin_out == (output_initial_state_in ^ output_polarity_in))
    else $error("leading level wrong");

  cap_no_wave_a : assert property (@(posedge clock_in) disable iff (!rst_s_r)
    cap_mode |-> !timer_out_pin_out) else $error("waveform in capture mode");
endmodule

// ### ptpc_pins.sv
// Pin model for the timer's external clock and capture pins
`timescale 1ns/1ns
module ptpc_pins
(
  input  wire logic       clock_in,
  input  wire logic       slow_in,
  input  wire logic [1:0] req_in,
  output logic      [1:0] pin_out
);
  // ----------------------------------------
  // Delay line
  // ----------------------------------------
  logic [1:0] s0_r = 2'h0;
  logic [1:0] s1_r = 2'h0;
  logic [1:0] s2_r = 2'h0;
  initial pin_out = 2'h0;
  // pins move off sampling edge
  // Slow setting adds three cycles of lag
  always @(negedge clock_in)
  begin
    s0_r    <= req_in;
    s1_r    <= s0_r;
    s2_r    <= s1_r;
    pin_out <= slow_in ? s2_r : req_in;
  end
endmodule

// ### ptpc_timer_tb.sv
// Self-checking bench for the timer pulse and capture block
`timescale 1ns/1ns
module ptpc_timer_tb;
  import ptpc_pkg::*;
  typedef struct packed {
    logic       sp;
    logic [9:0] v;
    logic [1:0] pf;
    logic       src, pin, lvl, xp, slow;
  } ptpc_row_t;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       clock_in = 1'b0, rst_b_in = 1'b0;
  logic [1:0] mode = 2'h0, pf = 2'h0, req = 2'h0, pins;
  logic       ccs = 1'b0, init = 1'b0, pol = 1'b0, src = 1'b0, slow = 1'b0;
  logic       rs = 1'b0, rc = 1'b0, cawr = 1'b0, caclr = 1'b0, cpclr = 1'b0;
  logic [9:0] cawd = 10'h000, per = 10'h000, cnt, ca;
  logic       run, opin, fa, fp;
  int         err_count = 0, samples_checked = 0, ecnt = 0, r = 0, n = 0, q = 0;
  ptpc_row_t  w;
  // Single rows: v is compare A, pf is init and polarity, src is clear select
  ptpc_row_t  rows [14] = '{
    '{1, 10'h000, 2'h0, 0, 0, 0, 0, 0}, '{1, 10'h005, 2'h2, 1, 0, 0, 0, 0},
    '{1, 10'h009, 2'h1, 0, 0, 0, 0, 0}, '{1, 10'h3FE, 2'h3, 1, 0, 0, 0, 0},
    '{0, 10'h000, PF_RISE, 0, 0, 1, 1, 0}, '{0, 10'h000, PF_RISE, 0, 0, 0, 0, 1},
    '{0, 10'h000, PF_FALL, 1, 1, 0, 1, 1}, '{0, 10'h000, PF_FALL, 1, 1, 1, 0, 0},
    '{0, 10'h000, PF_BOTH, 0, 0, 1, 1, 0}, '{0, 10'h000, PF_BOTH, 1, 1, 0, 1, 0},
    '{0, 10'h000, PF_NONE, 0, 0, 1, 0, 0}, '{0, 10'h000, PF_NONE, 1, 1, 0, 0, 1},
    '{0, 10'h000, PF_RISE, 0, 1, 1, 0, 0}, '{0, 10'h000, PF_RISE, 1, 0, 1, 0, 0}};

  ptpc_timer DUT (
    .clock_in(clock_in), .rst_b_in(rst_b_in), .mode_select_hi_in(mode[1]), .mode_select_lo_in(mode[0]),
    .pin_function_hi_in(pf[1]), .pin_function_lo_in(pf[0]), .counter_clear_select_in(ccs),
    .output_initial_state_in(init), .output_polarity_in(pol), .capture_source_select_in(src),
    .run_set_in(rs), .run_clear_in(rc), .compare_a_wr_in(cawr), .compare_a_wdata_in(cawd),
    .compare_p_period_in(per), .compare_a_flag_clr_in(caclr), .compare_p_flag_clr_in(cpclr),
    .timer_ext_clock_pin_in(pins[1]), .capture_input_pin_in(pins[0]), .timer_run_bit_out(run),
    .counter_out(cnt), .compare_a_value_out(ca), .timer_out_pin_out(opin),
    .compare_a_irq_flag_out(fa), .compare_p_irq_flag_out(fp));
  ptpc_pins PINS (.clock_in(clock_in), .slow_in(slow), .req_in(req), .pin_out(pins));

  initial forever #50 clock_in = ~clock_in;
  // Edge index, read only at falling edges
  always @(posedge clock_in) ecnt <= ecnt + 1;

  // ----------------------------------------
  // Helper tasks
  // ----------------------------------------
  task chk(input logic [9:0] s, input logic [9:0] e);
    samples_checked++;
    if (s !== e)
    begin
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
      err_count++;
    end
  endtask
  task end_of_test;
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(negedge clock_in);
  endtask
  // One-cycle strobes; callers leave a cycle between two calls
  task strobe(input logic [4:0] m);
    {rs, rc, cawr, caclr, cpclr} <= m;
    cyc(1);
    {rs, rc, cawr, caclr, cpclr} <= 5'h00;
  endtask
  task rst_chk;
    rst_b_in <= 1'b0;
    cyc(12);
    chk(10'({run, opin, fa, fp}), 10'h000);
    chk(cnt | ca, 10'h000);
    rst_b_in <= 1'b1;
    cyc(4);
  endtask
  task sp_row;
    mode <= MODE_SINGLE;
    pf <= PF_SINGLE;
    {init, pol} <= w.pf;
    ccs <= w.src;
    per <= w.v >> 1;
    cawd <= w.v;
    strobe(5'h06);
    cyc(1);
    strobe(5'h10);
    chk(10'(run), 10'h001);
    chk(cnt, 10'h000);
    chk(10'(opin), 10'(init ^ pol));
    n = 0;
    while (run === 1'b1 && n < 1100)
    begin
      n++;
      cyc(1);
    end
    if (n == 1100)
    begin
      err_count++;
      end_of_test();
    end
    chk(10'(n), w.v + 10'h001);
    chk(10'(fa), 10'h001);
    chk(cnt, w.v);
    chk(10'(opin), 10'(!(init ^ pol)));
    cyc(3);
    chk(cnt, w.v);
  endtask
  // Period of 21 counts equals the 21-cycle row, so every capture lands on one count (three later when slow)
  task cap_row;
    if (mode !== MODE_CAPTURE)
    begin
      mode <= MODE_CAPTURE;
      per <= 10'h014;
      r = ecnt + 1;
      strobe(5'h10);
    end
    pf <= w.pf;
    src <= w.src;
    slow <= w.slow;
    req <= {2{!w.lvl}};
    cawd <= 10'h155;
    cyc(10);
    strobe(5'h06);
    q = ecnt;
    req[w.pin] <= w.lvl;
    cyc(10);
    chk(ca, w.xp ? 10'((q + 3 + (w.slow ? 3 : 0) - r) % 21) : 10'h155);
    chk(10'(fa), 10'(w.xp));
    chk(10'(opin), 10'h000);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    rst_chk();
    foreach (rows[i])
    begin
      w = rows[i];
      if (w.sp)
        sp_row();
      else
        cap_row();
    end
    chk(10'(fp), 10'h001);
    per <= 10'h000;
    strobe(5'h09);
    cyc(1);
    r = ecnt + 1;
    strobe(5'h10);
    cyc(1030);
    chk(cnt, 10'(ecnt - r));
    chk(10'(fp), 10'h000);
    req <= 2'h0;
    slow <= 1'b1;
    mode <= MODE_SINGLE;
    pf <= PF_SINGLE;
    {init, pol} <= 2'h2;
    cawd <= 10'h004;
    strobe(5'h0E);
    cyc(6);
    req <= 2'h2;
    cyc(8);
    chk(10'(run), 10'h001);
    chk(10'(opin), 10'h001);
    strobe(5'h08);
    chk(10'(run), 10'h000);
    chk(10'(opin | fa), 10'h000);
    rst_chk();
    cyc(4);
    chk(10'(run), 10'h000);
    end_of_test();
  end
endmodule
